// >>> cbtd_map.svh
/*
 * Offsets-free constant map of the cell-balance timer and discharge block:
 * prescaler codes, step lengths, cell groups and all timing counts.
 * Assumes a 40 MHz core clock; included by bare name.
 */
`ifndef CBTD_MAP_SVH
`define CBTD_MAP_SVH

// core clock and base tick
`define CBTD_CLK_PERIOD_NS      25
`define CBTD_TICK_PERIOD_US     62500
`define CBTD_TICK_CYCLES        ((`CBTD_TICK_PERIOD_US * 1000) / `CBTD_CLK_PERIOD_NS)
`define CBTD_TICKS_PER_SEC      (1000000 / `CBTD_TICK_PERIOD_US)
`define CBTD_ALIVE_PERIOD_MS    500
`define CBTD_ALIVE_TICKS        ((`CBTD_ALIVE_PERIOD_MS * 1000) / `CBTD_TICK_PERIOD_US)

// emergency discharge windows
`define CBTD_WINDOW_S           60
`define CBTD_WINDOW_TICKS       (`CBTD_WINDOW_S * `CBTD_TICKS_PER_SEC)
`define CBTD_DUTY_STEP_MS       7500
`define CBTD_DUTY_STEP_TICKS    ((`CBTD_DUTY_STEP_MS * 1000) / `CBTD_TICK_PERIOD_US)
`define CBTD_MIN_OFF_TICKS      1
`define CBTD_TIMEOUT_STEP_H     2
`define CBTD_TIMEOUT_STEP_WIN   (`CBTD_TIMEOUT_STEP_H * 60)

// cell groups, cell 1 is bit 0
`define CBTD_ODD_CELLS          12'h555
`define CBTD_EVEN_CELLS         12'hAAA

// watchdog prescaler codes and last second index of each step
`define CBTD_PRESC_OFF          3'h0
`define CBTD_PRESC_1S           3'h1
`define CBTD_PRESC_4S           3'h2
`define CBTD_PRESC_16S          3'h3
`define CBTD_PRESC_64S          3'h4
`define CBTD_PRESC_128S         3'h5
`define CBTD_PRESC_256S         3'h6
`define CBTD_STEP_LAST_1S       8'h00
`define CBTD_STEP_LAST_4S       8'h03
`define CBTD_STEP_LAST_16S      8'h0F
`define CBTD_STEP_LAST_64S      8'h3F
`define CBTD_STEP_LAST_128S     8'h7F
`define CBTD_STEP_LAST_256S     8'hFF

`endif

// >>> cbtd_pkg.sv
/*
 * Types of the cell-balance timer and discharge block: configuration and
 * status bundles and the discharge mode states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package cbtd_pkg;

    typedef struct packed {
        logic [11:0] balance_switch_enable_mask;
        logic [11:0] discharge_switch_mask;
        logic [2:0]  watchdog_prescale_sel;
        logic        aux_pin3_timer_output_sel;
        logic        emergency_discharge_enable;
        logic [7:0]  discharge_timeout_sel;
        logic [2:0]  discharge_duty_sel;
        logic        pin3_normal_drive;
        logic        pin3_normal_level;
    } cbtd_cfg_t;

    typedef struct packed {
        logic [11:0] balance_switch_on;
        logic [3:0]  watchdog_countdown;
        logic        watchdog_expired;
        logic        discharge_active;
        logic [3:0]  discharge_alive_counter;
    } cbtd_stat_t;

    typedef enum logic [1:0] {
        CBTD_IDLE   = 2'b01,
        CBTD_ACTIVE = 2'b10
    } cbtd_state_t;

endpackage : cbtd_pkg

`default_nettype wire

// >>> cbtd_timebase.sv
/*
 * Base tick generator: one-cycle pulse every CYCLES enabled clocks.
 * Assumes a synchronous active-high reset and a clock enable.
 */
`default_nettype none

module cbtd_timebase #(
    parameter int unsigned CYCLES = 2500000
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    output var  logic tick
);
    localparam int unsigned W = $clog2(CYCLES);

    logic [W-1:0] cnt_q;
    wire          last = (cnt_q == W'(CYCLES - 1));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= last ? '0 : cnt_q + W'(1);
            tick  <= last;
        end
    end

endmodule : cbtd_timebase

`default_nettype wire

// >>> cbtd_top.sv
/*
 * Cell-balance watchdog and emergency-discharge controller: drives the
 * twelve balancing switches and the auxiliary pin 3. Every output is
 * registered and changes on the edge that takes the causing input, so
 * switches, pin and status flags never disagree for a cycle.
 * Assumes configuration comes from registers on the same clock, a single
 * 40 MHz clock and a synchronous active-high reset.
 */
//
// Behaviour
// R01: expiry forces switches off, mask kept
// R02: prescaler code selects step, zero disables
// R03: countdown times step gives 1s..3840s
// R04: expired stays off until disable or rewrite
// R05: host refreshes countdown before reaching zero
// R06: timer select drives pin high while counting
// R07: discharge starts on enable with nonzero timeout
// R08: entering discharge clears watchdog countdown
// R09: discharge mask replaces balance mask
// R10: entering discharge starts timeout timer
// R11: alive counter counts at 2Hz, wraps
// R12: pin high while discharge countdown active
// R13: alternate odd and even one-minute windows
// R14: each window ends with 62.5ms off
// R15: duty code sets on-time, 7.5s steps
// R16: timeout code counts two hours per step
// R17: clearing enable ends mode, resets timer
// R18: on exit, normal mask and pin control
// R19: zero timeout or elapsed timeout ends mode
// R20: countdown decrements once per step period
`default_nettype none
`include "cbtd_map.svh"

module cbtd_top #(
    parameter int unsigned TICK_CYCLES = `CBTD_TICK_CYCLES
) (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    input  wire cbtd_pkg::cbtd_cfg_t cfg,
    input  wire logic                countdown_we,
    input  wire logic [3:0]          countdown_wdata,
    output var  cbtd_pkg::cbtd_stat_t stat,
    output var  logic                general_pin_3_out,
    output var  logic                general_pin_3_oe_n
);
    localparam int unsigned WIN_TICKS  = `CBTD_WINDOW_TICKS;
    localparam int unsigned DUTY_TICKS = `CBTD_DUTY_STEP_TICKS;
    localparam int unsigned OFF_TICKS  = `CBTD_MIN_OFF_TICKS;
    localparam int unsigned TPS        = `CBTD_TICKS_PER_SEC;
    localparam int unsigned ALIVE_T    = `CBTD_ALIVE_TICKS;
    localparam int unsigned TO_WIN     = `CBTD_TIMEOUT_STEP_WIN;

    // base tick of 62.5 ms
    logic tick;

    cbtd_timebase #(
        .CYCLES (TICK_CYCLES)
    ) u_timebase (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .tick    (tick)
    );

    // watchdog state
    logic [3:0] wd_cnt_q;
    logic [3:0] wd_cnt_d;
    logic [3:0] wd_sub_q;
    logic [7:0] wd_sec_q;

    // discharge state
    cbtd_pkg::cbtd_state_t st_q;
    cbtd_pkg::cbtd_state_t st_d;
    logic        blocked_q;
    logic        odd_phase_q;
    logic [9:0]  win_tick_q;
    logic [15:0] win_cnt_q;
    logic [3:0]  alive_q;

    // prescaler decode
    wire [2:0] psel = cfg.watchdog_prescale_sel;
    wire wd_on = (psel != `CBTD_PRESC_OFF) &&
                 (psel <= `CBTD_PRESC_256S);               // R02
    wire [7:0] step_last =
        (psel == `CBTD_PRESC_1S)   ? `CBTD_STEP_LAST_1S   :
        (psel == `CBTD_PRESC_4S)   ? `CBTD_STEP_LAST_4S   :
        (psel == `CBTD_PRESC_16S)  ? `CBTD_STEP_LAST_16S  :
        (psel == `CBTD_PRESC_64S)  ? `CBTD_STEP_LAST_64S  :
        (psel == `CBTD_PRESC_128S) ? `CBTD_STEP_LAST_128S :
                                     `CBTD_STEP_LAST_256S; // R02 R03

    wire wd_counting = wd_on && (wd_cnt_q != 4'h0);
    // output-side views use the next countdown, so a write, a step and
    // an entry into discharge show on switches, pin and flag together
    wire wd_expired_d  = wd_on && (wd_cnt_d == 4'h0);      // R04
    wire wd_counting_d = wd_on && (wd_cnt_d != 4'h0);      // R06
    wire sec_pulse   = tick && (wd_sub_q == 4'(TPS - 1));
    wire step_end    = sec_pulse && (wd_sec_q == step_last);

    // discharge decode
    wire active    = (st_q == cbtd_pkg::CBTD_ACTIVE);
    wire active_d  = (st_d == cbtd_pkg::CBTD_ACTIVE);
    wire to_zero   = (cfg.discharge_timeout_sel == 8'h00);
    wire start     = !active && !blocked_q &&
                     cfg.emergency_discharge_enable && !to_zero; // R07
    // limit in windows: code + 1 steps of two hours, so 01h lasts four
    // hours; the count ends on the last tick of the final window
    wire [15:0] to_limit =
        16'((32'(cfg.discharge_timeout_sel) + 32'd1) * TO_WIN);  // R16
    wire win_last  = tick && (win_tick_q == 10'(WIN_TICKS - 1));
    wire timed_out = win_last && ((win_cnt_q + 16'h0001) >= to_limit);
    wire stop      = active && (!cfg.emergency_discharge_enable ||
                                to_zero || timed_out);        // R17 R19

    // on-time per window, last code trimmed so one off tick remains
    wire [9:0] on_full =
        10'((32'(cfg.discharge_duty_sel) + 32'd1) * DUTY_TICKS); // R15
    wire [9:0] on_ticks =
        (on_full > 10'(WIN_TICKS - OFF_TICKS)) ?
        10'(WIN_TICKS - OFF_TICKS) : on_full;                 // R14
    // the off tail of each window keeps odd and even groups from ever
    // conducting together, whatever the duty code
    wire sw_on_phase = (win_tick_q < on_ticks);
    wire [11:0] group = odd_phase_q ? `CBTD_ODD_CELLS : `CBTD_EVEN_CELLS;
    wire [11:0] dchg_sw =
        sw_on_phase ? (cfg.discharge_switch_mask & group) : 12'h000; // R13

    // mode state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            cbtd_pkg::CBTD_IDLE: begin
                if (start) begin
                    st_d = cbtd_pkg::CBTD_ACTIVE;
                end
            end
            cbtd_pkg::CBTD_ACTIVE: begin
                if (stop) begin
                    st_d = cbtd_pkg::CBTD_IDLE;
                end
            end
            default: begin
                st_d = cbtd_pkg::CBTD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= cbtd_pkg::CBTD_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // a mode that timed out with the enable still set must not restart
    // until software drops the enable
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            blocked_q <= 1'b0;
        end else if (clk_en) begin
            if (!cfg.emergency_discharge_enable) begin
                blocked_q <= 1'b0;
            end else if (stop) begin
                blocked_q <= 1'b1;
            end
        end
    end

    // window position and odd/even phase
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            win_tick_q  <= 10'h000;
            odd_phase_q <= 1'b1;
        end else if (clk_en) begin
            if (!active || stop) begin
                win_tick_q  <= 10'h000;                       // R17
                odd_phase_q <= 1'b1;
            end else if (win_last) begin
                win_tick_q  <= 10'h000;
                odd_phase_q <= !odd_phase_q;                  // R13
            end else if (tick) begin
                win_tick_q  <= win_tick_q + 10'h001;
            end
        end
    end

    // timeout timer counts whole windows; it restarts from zero on every
    // entry, so a new mode never inherits elapsed time
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            win_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            if (!active || stop) begin
                win_cnt_q <= 16'h0000;                        // R10 R17
            end else if (win_last) begin
                win_cnt_q <= win_cnt_q + 16'h0001;            // R16
            end
        end
    end

    // alive counter, held while idle and kept across entries
    wire       alive_step = active && tick &&
                            (win_tick_q[2:0] == 3'(ALIVE_T - 1));
    wire [3:0] alive_d    = alive_step ? alive_q + 4'h1 : alive_q; // R11

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            alive_q <= 4'h0;
        end else if (clk_en) begin
            alive_q <= alive_d;
        end
    end

    // watchdog countdown; a host write restarts the step so the first
    // step after a refresh is at most one free-running tick short
    always_comb begin
        wd_cnt_d = wd_cnt_q;
        // entry wins over a host write in the same cycle, so discharge
        // always begins with the countdown at zero
        if (start) begin
            wd_cnt_d = 4'h0;                                  // R08
        end else if (countdown_we) begin
            wd_cnt_d = countdown_wdata;                       // R04
        end else if (wd_counting && step_end) begin
            wd_cnt_d = wd_cnt_q - 4'h1;                       // R20
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wd_cnt_q <= 4'h0;
        end else if (clk_en) begin
            wd_cnt_q <= wd_cnt_d;
        end
    end

    // step phase: sixteen ticks make a second, step_last + 1 seconds a
    // step; it idles at zero whenever nothing is counting
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wd_sub_q <= 4'h0;
            wd_sec_q <= 8'h00;
        end else if (clk_en) begin
            if (countdown_we || !wd_counting) begin
                wd_sub_q <= 4'h0;
                wd_sec_q <= 8'h00;
            end else if (tick) begin
                wd_sub_q <= sec_pulse ? 4'h0 : wd_sub_q + 4'h1;
                if (step_end) begin
                    wd_sec_q <= 8'h00;                        // R03
                end else if (sec_pulse) begin
                    wd_sec_q <= wd_sec_q + 8'h01;
                end
            end
        end
    end

    // switch selection; the mask itself is never altered here
    wire [11:0] bal_sw =
        wd_expired_d ? 12'h000 : cfg.balance_switch_enable_mask; // R01
    wire [11:0] sw_d = active_d ? dchg_sw : bal_sw;           // R09 R18

    // pin 3 source: discharge first, then the watchdog, then the
    // normal pin configuration
    wire pin_drive_d = active_d || cfg.aux_pin3_timer_output_sel ||
                       cfg.pin3_normal_drive;                 // R18
    wire pin_level_d =
        active_d                      ? 1'b1 :                // R12
        cfg.aux_pin3_timer_output_sel ? wd_counting_d :       // R06
                                        cfg.pin3_normal_level; // R18

    // registered status
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat <= '0;
        end else if (clk_en) begin
            stat.balance_switch_on       <= sw_d;
            stat.watchdog_countdown      <= wd_cnt_d;
            stat.watchdog_expired        <= wd_expired_d;
            stat.discharge_active        <= active_d;
            stat.discharge_alive_counter <= alive_d;
        end
    end

    // registered pin; released out of reset so nothing is driven onto
    // the line before configuration settles
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            general_pin_3_out  <= 1'b0;
            general_pin_3_oe_n <= 1'b1;
        end else if (clk_en) begin
            general_pin_3_out  <= pin_level_d;
            general_pin_3_oe_n <= !pin_drive_d;
        end
    end

endmodule : cbtd_top

`default_nettype wire

// >>> cbtd_top_sva.sv
/* checker for cbtd_top: switch, pin 3 and discharge relations.
   assumes clk_en held high and binding at the cbtd_top ports. */
`default_nettype none
module cbtd_chk (
    input wire logic                 clock,
    input wire logic                 sys_rst,
    input wire cbtd_pkg::cbtd_cfg_t  cfg,
    input wire logic                 countdown_we,
    input wire logic [3:0]           countdown_wdata,
    input wire cbtd_pkg::cbtd_stat_t stat,
    input wire logic                 general_pin_3_out,
    input wire logic                 general_pin_3_oe_n
);
    wire logic        act = stat.discharge_active;
    wire logic [11:0] sw  = stat.balance_switch_on;
    wire logic [3:0]  alv = stat.discharge_alive_counter;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    expiry_off_a: assert property (
        stat.watchdog_expired && !act |-> sw == 12'h000)
        else $error("switches on after expiry");
    write_load_a: assert property (
        countdown_we && !cfg.emergency_discharge_enable && !act
        |=> stat.watchdog_countdown == $past(countdown_wdata))
        else $error("countdown write lost");
    no_start_a: assert property (
        !act && cfg.discharge_timeout_sel == 8'h00 |=> !act)
        else $error("discharge began with zero timeout");
    entry_clear_a: assert property (
        $rose(act) |-> stat.watchdog_countdown == 4'h0)
        else $error("countdown kept on entry");
    dchg_pin_a: assert property (
        act |-> general_pin_3_out && !general_pin_3_oe_n)
        else $error("pin 3 not high in discharge");
    dchg_mask_a: assert property (
        act |-> (sw & ~$past(cfg.discharge_switch_mask)) == 12'h000)
        else $error("switch outside discharge mask");
    group_gap_a: assert property (
        act && (sw & 12'h555) != 12'h000
        |=> !act || (sw & 12'hAAA) == 12'h000)
        else $error("odd and even groups overlap");
    mode_stop_a: assert property (
        act && (!cfg.emergency_discharge_enable
        || cfg.discharge_timeout_sel == 8'h00) |=> !act)
        else $error("discharge did not stop");
    alive_step_a: assert property (
        act && $past(act) |-> 4'(alv - $past(alv)) inside {4'h0, 4'h1})
        else $error("alive counter jumped");
    alive_hold_a: assert property (
        !act && !$past(act) |-> $stable(alv))
        else $error("alive counter moved while idle");

    cover property (stat.watchdog_expired);
    cover property ($rose(act));
    cover property ($fell(act));
endmodule : cbtd_chk

bind cbtd_top cbtd_chk i_chk (.clock(clock), .sys_rst(sys_rst), .cfg(cfg),
    .countdown_we(countdown_we), .countdown_wdata(countdown_wdata),
    .stat(stat), .general_pin_3_out(general_pin_3_out),
    .general_pin_3_oe_n(general_pin_3_oe_n));
`default_nettype wire

// >>> cbtd_top_tb.sv
/* self-checking bench for cbtd_top: watchdog steps and expiry, pin 3,
   discharge windows. assumes a 2-clock tick to keep the run short. */
`default_nettype none
module cbtd_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TK = 2;
    typedef struct {
        string       nm;
        int          sel;
        logic [11:0] ex;
    } cbtd_note_t;
    logic                 clock           = 1'b0;
    logic                 sys_rst         = 1'b1;
    logic                 countdown_we    = 1'b0;
    logic [3:0]           countdown_wdata = 4'h0;
    cbtd_pkg::cbtd_cfg_t  cfg             = '0;
    cbtd_pkg::cbtd_stat_t stat;
    logic                 pin_o;
    logic                 pin_oe_n;
    cbtd_note_t           q[$];
    int                   err_total       = 0;
    int                   samples_checked = 0;
    int                   cnt;
    logic [11:0]          bm;
    logic [11:0]          dm;
    logic [3:0]           a0;

    always #12.5 clock = ~clock;

    cbtd_top #(.TICK_CYCLES(TK)) i_dut (.clock(clock), .sys_rst(sys_rst),
        .clk_en(1'b1), .cfg(cfg), .countdown_we(countdown_we),
        .countdown_wdata(countdown_wdata), .stat(stat),
        .general_pin_3_out(pin_o), .general_pin_3_oe_n(pin_oe_n));

    function automatic logic [11:0] pick(input int sel);
        case (sel)
            0: return stat.balance_switch_on;
            1: return {8'h00, stat.watchdog_countdown};
            2: return {11'h000, stat.watchdog_expired};
            3: return {11'h000, stat.discharge_active};
            4: return {11'h000, pin_o};
            5: return {11'h000, pin_oe_n};
            default: return {8'h00, stat.discharge_alive_counter};
        endcase
    endfunction : pick

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string nm, input logic [11:0] seen,
                         input logic [11:0] ex);
        samples_checked++;
        if (seen !== ex) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask : check

    task automatic note(input string nm, input int sel, input logic [11:0] ex);
        q.push_back('{nm, sel, ex});
    endtask : note

    // outputs are settled at the falling edge, so no race with the design
    always @(negedge clock) begin : mon
        cbtd_note_t n;
        while (q.size() > 0) begin
            n = q.pop_front();
            check(n.nm, pick(n.sel), n.ex);
        end
    end

    task automatic wait_for(input int sel, input logic [11:0] v,
                            input int lim);
        cnt = 0;
        do begin
            @(negedge clock);
            cnt++;
        end while (pick(sel) !== v && cnt < lim);
        if (pick(sel) !== v) begin
            err_total++;
            $display("BAD wait on field %0d", sel);
            complete_run();
        end
        @(posedge clock);
    endtask : wait_for

    // tick divider phase is free running, hence a small tolerance
    task automatic near(input string nm, input int ex, input int tol);
        check(nm, 12'(cnt >= ex - tol && cnt <= ex + tol), 12'h001);
    endtask : near

    task automatic wr(input logic [3:0] v);
        countdown_we    <= 1'b1;
        countdown_wdata <= v;
        @(posedge clock);
        countdown_we    <= 1'b0;
    endtask : wr

    initial begin : main
        int step_s [6] = '{1, 4, 16, 64, 128, 256};
        void'($urandom(69790));
        bm = 12'($urandom) | 12'h801;
        dm = 12'($urandom) | 12'h0C3;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        cfg.balance_switch_enable_mask <= bm;
        cfg.discharge_switch_mask      <= dm;
        cfg.aux_pin3_timer_output_sel  <= 1'b1;
        repeat (2) @(posedge clock);
        note("bal_mask", 0, bm);
        for (int i = 0; i < 6; i++) begin
            cfg.watchdog_prescale_sel <= 3'(i + 1);
            wr(4'h1);
            @(posedge clock);
            note("counting_sw", 0, bm);
            note("pin_hi", 4, 12'h001);
            note("pin_drv", 5, 12'h000);
            wait_for(2, 12'h001, 16 * step_s[i] * TK + 20);
            near("expiry_time", 16 * step_s[i] * TK, 4);
            note("off_sw", 0, 12'h000);
            note("pin_lo", 4, 12'h000);
        end
        repeat (40) @(posedge clock);
        note("stay_off", 0, 12'h000);
        cfg.watchdog_prescale_sel <= 3'h0;
        repeat (2) @(posedge clock);
        note("disabled_on", 0, bm);
        cfg.watchdog_prescale_sel <= 3'h1;
        repeat (2) @(posedge clock);
        note("reenabled_off", 0, 12'h000);
        wr(4'h3);
        @(posedge clock);
        note("rewrite_on", 0, bm);
        wait_for(1, 12'h002, 16 * TK + 20);
        near("step_time", 16 * TK, 4);
        cfg.emergency_discharge_enable <= 1'b1;
        repeat (3) @(posedge clock);
        note("no_timeout", 3, 12'h000);
        cfg.emergency_discharge_enable <= 1'b0;
        @(posedge clock);
        cfg.emergency_discharge_enable <= 1'b1;
        cfg.discharge_timeout_sel      <= 8'h01;
        repeat (2) @(posedge clock);
        note("active", 3, 12'h001);
        note("cd_clear", 1, 12'h000);
        note("odd_win", 0, dm & 12'h555);
        note("pin_dchg", 4, 12'h001);
        note("pin_dchg_drv", 5, 12'h000);
        wait_for(0, 12'h000, 300);
        near("duty0_on", 120 * TK, 4);
        wait_for(0, dm & 12'hAAA, 1800);
        near("duty0_off", 840 * TK, 4);
        cfg.discharge_duty_sel <= 3'h7;
        @(negedge clock);
        a0 = stat.discharge_alive_counter;
        repeat (160) @(posedge clock);
        note("alive", 6, {8'h00, a0 + 4'hA});
        wait_for(0, 12'h000, 2000);
        wait_for(0, dm & 12'h555, 20);
        near("min_off", TK, 0);
        wait_for(0, 12'h000, 2000);
        near("duty7_on", 959 * TK, 4);
        cfg.watchdog_prescale_sel     <= 3'h0;
        cfg.aux_pin3_timer_output_sel <= 1'b0;
        @(posedge clock);
        cfg.emergency_discharge_enable <= 1'b0;
        repeat (2) @(posedge clock);
        note("ended", 3, 12'h000);
        note("back_bal", 0, bm);
        note("pin_normal", 5, 12'h001);
        cfg.emergency_discharge_enable <= 1'b1;
        repeat (2) @(posedge clock);
        note("restart_odd", 0, dm & 12'h555);
        cfg.discharge_timeout_sel <= 8'h00;
        cfg.pin3_normal_drive     <= 1'b1;
        repeat (2) @(posedge clock);
        note("zero_stop", 3, 12'h000);
        note("zero_bal", 0, bm);
        note("pin_cfg_lvl", 4, 12'h000);
        note("pin_cfg_drv", 5, 12'h000);
        @(posedge clock);
        complete_run();
    end
endmodule : cbtd_top_tb
`default_nettype wire
